// *** hw/fcvp_pkg.sv ***
// Package of constants and register map for the four-channel voice playback block
package fcvp_pkg;
    localparam int unsigned CHANNELS      = 4;
    localparam int unsigned ROM_WORD_W    = 10;
    localparam int unsigned ROM_DEPTH     = 829440;      // 810K words
    localparam int unsigned ROM_ADDR_W    = 20;
    localparam int unsigned PERIOD_W      = 16;          // Quarter-microsecond units
    localparam int unsigned VOLF_W        = 6;
    localparam int unsigned SAMPLE_W      = 8;
    localparam int unsigned PROD_W        = 14;
    localparam int unsigned MIX_W         = 14;

    // Timing
    localparam real         CLK_MHZ       = 100.0;
    localparam real         PERIOD_STEP_NS = 250.0;      // 0.25 us resolution
    localparam int unsigned STEP_CYCLES   = int'(PERIOD_STEP_NS * CLK_MHZ / 1000.0);
    localparam real         RATE_MIN_KHZ  = 4.0;
    localparam real         RATE_MAX_KHZ  = 40.0;
    localparam logic [15:0] PERIOD_MIN    = 16'(int'(1000.0 / RATE_MAX_KHZ / 0.25));
    localparam logic [15:0] PERIOD_MAX    = 16'(int'(1000.0 / RATE_MIN_KHZ / 0.25));

    // Wave data: a word with top bits 2'b11 carries an event code in its low byte
    localparam logic [1:0]  MARK_TAG      = 2'h3;

    // Register byte offsets (each one aligned word)
    localparam logic [7:0]  OFF_VOLUME    = 8'h00;
    localparam logic [7:0]  OFF_CTRL      = 8'h04;       // Bit per channel: play enable
    localparam logic [7:0]  OFF_IRQ_STAT  = 8'h08;       // Read clears
    localparam logic [7:0]  OFF_IRQ_MASK  = 8'h0c;
    localparam logic [7:0]  OFF_MARK      = 8'h10;       // Last mark code, channel in [9:8]
    localparam logic [7:0]  OFF_CH_BASE   = 8'h40;       // Per-channel block of 0x10
    localparam logic [7:0]  CH_PERIOD     = 8'h0;
    localparam logic [7:0]  CH_START      = 8'h4;
    localparam logic [7:0]  CH_LOOP       = 8'h8;
    localparam logic [7:0]  CH_END        = 8'hc;
    localparam logic [3:0]  VOL_RESET     = 4'h7;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    localparam int unsigned IRQ_W         = 8;           // [3:0] ends, [7:4] marks
endpackage : fcvp_pkg

// *** hw/fcvp_top.sv ***
// Four-channel voice playback engine with register slave and push-pull output
//
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Four channels each run their own sampling-period counter.
// - Each channel's rate is programmable between 4 kHz and 40 kHz.
// - The period is counted in steps of 0.25 us.
// - Each channel loops its segment in hardware without software help.
// - All channels fetch from one shared ROM of 10-bit words, up to 810K deep.
// - Event codes found in wave data are latched and offered to the controller.
// - Samples are scaled by a 6-bit volume factor times an 8-bit operand.
// - Two mixers combine the channels with saturation.
// - Volume bits 2:0 pick one of eight levels, rising with the code.
// - Volume bit 3 halves the output amplitude.
// - The output stage takes 8-bit values with the LSB forced to zero.
// - The output drives a positive and a negative phase pin.
// - A high reset resets the whole block, channel state included.
module fcvp_top #(
    parameter int unsigned ROM_ADDR_W = fcvp_pkg::ROM_ADDR_W
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Avalon-MM slave
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Shared wave ROM, one-cycle read latency
    output logic      [ROM_ADDR_W-1:0] rom_addr,
    output logic                       rom_rd,
    input  wire logic [9:0]            rom_data,
    // Interrupt and speaker
    output logic                       irq,
    output logic      [7:0]            speaker_drive_positive,
    output logic      [7:0]            speaker_drive_negative
);
    localparam int unsigned NCH = fcvp_pkg::CHANNELS;

    // Narrower addresses cannot reach the whole ROM; widths above 24 bits are refused too, though the 32-bit readback would hold them
    if (ROM_ADDR_W < fcvp_pkg::ROM_ADDR_W || ROM_ADDR_W > 24) begin : g_bad_addr_w
        $error("fcvp_top: ROM_ADDR_W must cover 810K words");
    end
    if (NCH != 4) begin : g_bad_nch
        $error("fcvp_top: the fetch arbiter and mixers serve exactly four channels");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [3:0]            vol_reg, vol_next;
    logic [NCH-1:0]        en_reg, en_next;
    logic [7:0]            stat_reg, stat_next;
    logic [7:0]            mask_reg, mask_next;
    logic [9:0]            mark_reg, mark_next;
    logic [15:0]           per_reg  [NCH], per_next  [NCH];
    logic [ROM_ADDR_W-1:0] strt_reg [NCH], strt_next [NCH];
    logic [ROM_ADDR_W-1:0] lp_reg   [NCH], lp_next   [NCH];
    logic [ROM_ADDR_W-1:0] end_reg  [NCH], end_next  [NCH];
    logic [5:0]            gain_reg [NCH], gain_next [NCH];
    logic [31:0]           rdata_reg, rdata_next;
    logic                  ack_reg, ack_next;

    // Channel engine
    logic [7:0]            pre_reg  [NCH], pre_next  [NCH];
    logic [15:0]           cnt_reg  [NCH], cnt_next  [NCH];
    logic [ROM_ADDR_W-1:0] pos_reg  [NCH], pos_next  [NCH];
    logic [NCH-1:0]        pend_reg, pend_next;
    logic [7:0]            smp_reg  [NCH], smp_next  [NCH];
    logic [1:0]            fch_reg, fch_next;
    logic                  fv_reg, fv_next;
    logic [NCH-1:0]        adv;
    logic [NCH-1:0]        end_ev;
    logic                  mark_ev;
    logic [7:0]            out_p_reg, out_p_next;
    logic [7:0]            out_n_reg, out_n_next;

    logic       acc;
    logic [7:0] ch_off;
    logic [1:0] ch_sel;
    logic       ch_hit;

    assign acc    = (avs_read || avs_write) && !ack_reg;
    assign ch_off = avs_address - fcvp_pkg::OFF_CH_BASE;
    assign ch_sel = ch_off[5:4];
    assign ch_hit = avs_address >= fcvp_pkg::OFF_CH_BASE && ch_off < 8'(NCH * 16);
    // One wait cycle per access: the answer comes at the second edge
    assign avs_waitrequest = !ack_reg;
    assign avs_readdata    = rdata_reg;
    assign irq             = |(stat_reg & mask_reg);

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) r[8*b +: 8] = wd[8*b +: 8];
        end
        return r;
    endfunction : merge

    always_comb begin
        logic [31:0] m;
        m          = 32'h0;
        vol_next   = vol_reg;
        en_next    = en_reg;
        mask_next  = mask_reg;
        mark_next  = mark_reg;
        rdata_next = rdata_reg;
        ack_next   = acc;
        stat_next  = stat_reg;
        per_next   = per_reg;
        strt_next  = strt_reg;
        lp_next    = lp_reg;
        end_next   = end_reg;
        gain_next  = gain_reg;
        if (acc && avs_read) begin
            case (avs_address)
                fcvp_pkg::OFF_VOLUME:   rdata_next = {28'h0, vol_reg};
                fcvp_pkg::OFF_CTRL:     rdata_next = {28'h0, en_reg};
                fcvp_pkg::OFF_IRQ_STAT: rdata_next = {24'h0, stat_reg};
                fcvp_pkg::OFF_IRQ_MASK: rdata_next = {24'h0, mask_reg};
                fcvp_pkg::OFF_MARK:     rdata_next = {22'h0, mark_reg};
                default: begin
                    rdata_next = fcvp_pkg::UNMAPPED_DATA;
                    if (ch_hit) begin
                        case (ch_off[3:0])
                            fcvp_pkg::CH_PERIOD[3:0]: rdata_next = {10'h0, gain_reg[ch_sel], per_reg[ch_sel]};
                            fcvp_pkg::CH_START[3:0]:  rdata_next = 32'(strt_reg[ch_sel]);
                            fcvp_pkg::CH_LOOP[3:0]:   rdata_next = 32'(lp_reg[ch_sel]);
                            default: rdata_next = 32'(end_reg[ch_sel]);
                        endcase
                    end
                end
            endcase
            if (avs_address == fcvp_pkg::OFF_IRQ_STAT) stat_next = 8'h0;
        end
        if (acc && avs_write) begin
            case (avs_address)
                fcvp_pkg::OFF_VOLUME: begin
                    m        = merge({28'h0, vol_reg}, avs_writedata, avs_byteenable);
                    vol_next = m[3:0];
                end
                fcvp_pkg::OFF_CTRL: begin
                    m       = merge({28'h0, en_reg}, avs_writedata, avs_byteenable);
                    en_next = m[NCH-1:0];
                end
                fcvp_pkg::OFF_IRQ_MASK: begin
                    m         = merge({24'h0, mask_reg}, avs_writedata, avs_byteenable);
                    mask_next = m[7:0];
                end
                default: begin
                    if (ch_hit) begin
                        case (ch_off[3:0])
                            fcvp_pkg::CH_PERIOD[3:0]: begin
                                m = merge({10'h0, gain_reg[ch_sel], per_reg[ch_sel]}, avs_writedata, avs_byteenable);
                                // Clamp keeps the rate inside 4..40 kHz
                                if (m[15:0] < fcvp_pkg::PERIOD_MIN)      per_next[ch_sel] = fcvp_pkg::PERIOD_MIN;
                                else if (m[15:0] > fcvp_pkg::PERIOD_MAX) per_next[ch_sel] = fcvp_pkg::PERIOD_MAX;
                                else                                     per_next[ch_sel] = m[15:0];
                                gain_next[ch_sel] = m[21:16];
                            end
                            fcvp_pkg::CH_START[3:0]: begin
                                m = merge(32'(strt_reg[ch_sel]), avs_writedata, avs_byteenable);
                                strt_next[ch_sel] = m[ROM_ADDR_W-1:0];
                            end
                            fcvp_pkg::CH_LOOP[3:0]: begin
                                m = merge(32'(lp_reg[ch_sel]), avs_writedata, avs_byteenable);
                                lp_next[ch_sel] = m[ROM_ADDR_W-1:0];
                            end
                            default: begin
                                m = merge(32'(end_reg[ch_sel]), avs_writedata, avs_byteenable);
                                end_next[ch_sel] = m[ROM_ADDR_W-1:0];
                            end
                        endcase
                    end
                end
            endcase
        end
        // Events set after the read-clear so a same-cycle event survives
        stat_next = stat_next | {mark_ev ? (4'h1 << fch_reg) : 4'h0, end_ev};
        if (mark_ev) mark_next = {fch_reg, rom_data[7:0]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sampling counters and fetch arbiter
    always_comb begin
        logic found;
        found      = 1'b0;
        pre_next   = pre_reg;
        cnt_next   = cnt_reg;
        pos_next   = pos_reg;
        pend_next  = pend_reg;
        smp_next   = smp_reg;
        fch_next   = fch_reg;
        fv_next    = 1'b0;
        adv        = '0;
        end_ev     = '0;
        mark_ev    = 1'b0;
        rom_rd     = 1'b0;
        rom_addr   = '0;
        for (int c = 0; c < NCH; c++) begin
            if (!en_reg[c]) begin
                pre_next[c] = 8'h0;
                cnt_next[c] = per_reg[c];
                pos_next[c] = strt_reg[c];
                smp_next[c] = 8'h0;
            end else if (pre_reg[c] == 8'(fcvp_pkg::STEP_CYCLES - 1)) begin
                pre_next[c] = 8'h0; // One tick every 0.25 us
                if (cnt_reg[c] <= 16'h1) begin
                    cnt_next[c] = per_reg[c]; // Reload on expiry
                    adv[c]      = 1'b1;
                end else begin
                    cnt_next[c] = cnt_reg[c] - 16'h1;
                end
            end else begin
                pre_next[c] = pre_reg[c] + 8'h1;
            end
        end
        pend_next = (pend_reg | adv) & en_reg;
        // Fetch: one channel per cycle from the shared ROM; worst-case wait is 3 cycles
        for (int c = 0; c < NCH; c++) begin
            if (pend_reg[c] && !found && !(fv_reg && fch_reg == 2'(c))) begin
                found        = 1'b1;
                rom_rd       = 1'b1;
                rom_addr     = pos_reg[c];
                fch_next     = 2'(c);
                fv_next      = 1'b1;
                pend_next[c] = adv[c] & en_reg[c];
                if (pos_reg[c] >= end_reg[c]) begin
                    pos_next[c] = lp_reg[c]; // Hardware loop wrap
                    end_ev[c]   = 1'b1;
                end else begin
                    pos_next[c] = pos_reg[c] + 1'b1;
                end
            end
        end
        if (fv_reg && en_reg[fch_reg]) begin
            if (rom_data[9:8] == fcvp_pkg::MARK_TAG) mark_ev = 1'b1; // Mark word holds previous sample
            else smp_next[fch_reg] = rom_data[9:2]; // Top 8 of the 10-bit word
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Volume multiply, mixers, output stage
    // Mixer rails: wrapping would flip a loud peak into the opposite extreme
    localparam logic signed [13:0] MIX_HI = 14'sh1fff;
    localparam logic signed [13:0] MIX_LO = 14'sh2000;

    function automatic logic signed [13:0] sat_add(input logic signed [13:0] a, input logic signed [13:0] b);
        logic signed [14:0] s;
        s = 15'(a) + 15'(b);
        if (s > 15'(MIX_HI))      return MIX_HI;
        else if (s < 15'(MIX_LO)) return MIX_LO;
        else                     return s[13:0];
    endfunction : sat_add

    always_comb begin
        logic signed [13:0] prod [NCH];
        logic signed [13:0] mix_a, mix_b, mix;
        logic signed [13:0] lvl;
        logic [7:0]         u;
        prod  = '{default: 14'sh0};
        mix_a = 14'sh0;
        mix_b = 14'sh0;
        mix   = 14'sh0;
        lvl   = 14'sh0;
        u     = 8'h0;
        for (int c = 0; c < NCH; c++) begin
            // Signed 8-bit sample times unsigned 6-bit factor, arithmetic shift keeps 14 bits
            prod[c] = 14'((22'(signed'(smp_reg[c] ^ 8'h80)) * signed'({16'h0, gain_reg[c]})) >>> 1);
        end
        mix_a = sat_add(prod[0], prod[1]);
        mix_b = sat_add(prod[2], prod[3]);
        mix   = sat_add(mix_a, mix_b);
        // Eight levels: 3'h7 passes full, each step down attenuates
        lvl = mix >>> (3'h7 - vol_reg[2:0]);
        if (vol_reg[3]) lvl = lvl >>> 1;
        u          = lvl[13:6] ^ 8'h80;
        out_p_next = {u[7:1], 1'b0};
        out_n_next = {~u[7:1], 1'b0};
    end

    assign speaker_drive_positive = out_p_reg;
    assign speaker_drive_negative = out_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // State registers, all loaded with their reset values by the reset pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vol_reg   <= fcvp_pkg::VOL_RESET;
            en_reg    <= '0;
            stat_reg  <= 8'h0;
            mask_reg  <= 8'h0;
            mark_reg  <= 10'h0;
            rdata_reg <= 32'h0;
            ack_reg   <= 1'b0;
            pend_reg  <= '0;
            fch_reg   <= 2'h0;
            fv_reg    <= 1'b0;
            out_p_reg <= 8'h80;
            out_n_reg <= 8'h7e;
            for (int c = 0; c < NCH; c++) begin
                per_reg[c]  <= fcvp_pkg::PERIOD_MAX;
                strt_reg[c] <= '0;
                lp_reg[c]   <= '0;
                end_reg[c]  <= '0;
                gain_reg[c] <= 6'h0;
                pre_reg[c]  <= 8'h0;
                cnt_reg[c]  <= fcvp_pkg::PERIOD_MAX;
                pos_reg[c]  <= '0;
                smp_reg[c]  <= 8'h0;
            end
        end else begin
            vol_reg   <= vol_next;
            en_reg    <= en_next;
            stat_reg  <= stat_next;
            mask_reg  <= mask_next;
            mark_reg  <= mark_next;
            rdata_reg <= rdata_next;
            ack_reg   <= ack_next;
            pend_reg  <= pend_next;
            fch_reg   <= fch_next;
            fv_reg    <= fv_next;
            out_p_reg <= out_p_next;
            out_n_reg <= out_n_next;
            per_reg   <= per_next;
            strt_reg  <= strt_next;
            lp_reg    <= lp_next;
            end_reg   <= end_next;
            gain_reg  <= gain_next;
            pre_reg   <= pre_next;
            cnt_reg   <= cnt_next;
            pos_reg   <= pos_next;
            smp_reg   <= smp_next;
        end
    end
endmodule : fcvp_top
`default_nettype wire

// *** verif/fcvp_assertions.sv ***
// Checker of bus handshake, speaker pins and reset state of the playback engine
`timescale 1ns/10ps
`default_nettype none
module fcvp_assertions (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register bus
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Fetch, interrupt and speaker
    input wire logic        rom_rd,
    input wire logic        irq,
    input wire logic [7:0]  speaker_drive_positive,
    input wire logic [7:0]  speaker_drive_negative
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////
    property p_idle_wait;
        !avs_read && !avs_write |-> avs_waitrequest;
    endproperty
    a_idle_wait: assert property (p_idle_wait) else $error("wait low with no request");
    property p_wait_one;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait low over two cycles");
    property p_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered next cycle");
    property p_rdata_hold;
        $changed(avs_readdata) |-> avs_read && !avs_waitrequest;
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside an answer");
    property p_lsb_zero;
        speaker_drive_positive[0] == 1'b0 && speaker_drive_negative[0] == 1'b0;
    endproperty
    a_lsb_zero: assert property (p_lsb_zero) else $error("speaker lsb set");
    property p_phases;
        speaker_drive_negative == {~speaker_drive_positive[7:1], 1'b0};
    endproperty
    a_phases: assert property (p_phases) else $error("speaker phases disagree");
    property p_reset_state;
        $fell(rst) |-> speaker_drive_positive == 8'h80 && !irq && !rom_rd;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("state after reset wrong");
    property p_irq_fall;
        $fell(irq) |-> $past(avs_read || avs_write);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq dropped with no access");
endmodule : fcvp_assertions

bind fcvp_top fcvp_assertions fcvp_assertions_i (
    .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rom_rd(rom_rd), .irq(irq),
    .speaker_drive_positive(speaker_drive_positive), .speaker_drive_negative(speaker_drive_negative)
);
`default_nettype wire

// *** verif/fcvp_rom_model.sv ***
// Wave ROM model answering each fetch in the following cycle
`timescale 1ns/10ps
`default_nettype none
module fcvp_rom_model #(
    parameter int unsigned ADDR_W    = 20,
    parameter logic [7:0]  MARK_CODE = 8'h5a
) (
    // Clock
    input  wire logic              clk,
    // Fetch port
    input  wire logic [ADDR_W-1:0] rom_addr,
    input  wire logic              rom_rd,
    output logic      [9:0]        rom_data
);
    // Idle cycles toggle the word so stale data never looks valid
    initial rom_data = 10'h155;
    always @(posedge clk) begin
        if (rom_rd) begin
            rom_data <= (rom_addr[5:0] == 6'h22) ? {2'h3, MARK_CODE} : 10'h000;
        end else begin
            rom_data <= ~rom_data;
        end
    end
endmodule : fcvp_rom_model
`default_nettype wire

// *** verif/fcvp_top_bench.sv ***
// Bench programming all channels and checking fetches, status and speaker pins
`timescale 1ns/10ps
`default_nettype none
module fcvp_top_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [19:0] rom_addr;
    logic        rom_rd;
    logic [9:0]  rom_data;
    logic        irq;
    logic [7:0]  speaker_drive_positive;
    logic [7:0]  speaker_drive_negative;
    logic [63:0] note;
    logic [63:0] notes[$];
    logic [19:0] nxt[4];
    int          per[4] = '{100, 117, 103, 120};
    int          last[4];
    int          cyc = 0;
    int          c;
    int          mismatches = 0;
    int          n_compared = 0;
    bit          quiet = 1'b1;

    always #5 clk = ~clk;

    fcvp_top fcvp_top_i (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rom_addr(rom_addr),
        .rom_rd(rom_rd), .rom_data(rom_data), .irq(irq), .speaker_drive_positive(speaker_drive_positive),
        .speaker_drive_negative(speaker_drive_negative));
    fcvp_rom_model fcvp_rom_model_i (.clk(clk), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_data(rom_data));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check("bus answer", 32'(n >= 50), 32'h0);
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back({e & m, m});
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic arm;
        for (int k = 0; k < 4; k++) begin
            nxt[k]  = 20'(k * 16);
            last[k] = 0;
        end
    endtask : arm
    ////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc++;
        if (avs_read && avs_waitrequest === 1'b0) begin
            note = notes.pop_front();
            check("read data", avs_readdata & note[31:0], note[63:32]);
        end
        if (rom_rd === 1'b1) begin
            c = int'(rom_addr[5:4]);
            check("idle fetch", 32'(quiet), 32'h0);
            if (!quiet) begin
                check("fetch addr", 32'(rom_addr), 32'(nxt[c]));
                if (last[c] > 0) check("fetch gap", 32'((cyc - last[c] - per[c] * 25) inside {[0:3]}), 32'h1);
                nxt[c]  = (rom_addr[3:0] == 4'h3) ? rom_addr - 20'h2 : rom_addr + 20'h1;
                last[c] = cyc;
            end
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        logic [7:0] pe;
        int         mag;
        void'($urandom(35689));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h7, 32'hf);
        rd(8'h24, 32'h0, 32'hffffffff);
        arm();
        quiet <= 1'b0;
        // A period above the rate range reads back clamped; channel 0 asks for 10 and runs at the floor
        bus(1'b1, 8'h70, 32'h0000_044c);
        rd(8'h70, 32'h3e8, 32'hffff);
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'(8'h40 + k * 16), {10'h0, 6'(48 + $urandom_range(15)), 16'(k == 0 ? 10 : per[k])});
            bus(1'b1, 8'(8'h44 + k * 16), 32'(k * 16));
            bus(1'b1, 8'(8'h48 + k * 16), 32'(k * 16 + 1));
            bus(1'b1, 8'(8'h4c + k * 16), 32'(k * 16 + 3));
            bus(1'b1, 8'h04, 32'((2 << k) - 1));
        end
        bus(1'b1, 8'h0c, 32'h40);
        repeat (13000) @(posedge clk);
        check("irq mark", 32'(irq), 32'h1);
        bus(1'b1, 8'h0c, 32'h0);
        repeat (2) @(posedge clk);
        check("irq masked", 32'(irq), 32'h0);
        // Four most negative samples saturate the mix, so each code halves a full-scale swing
        for (int v = 0; v < 16; v++) begin
            bus(1'b1, 8'h00, 32'(v));
            rd(8'h00, 32'(v), 32'hf);
            repeat (8) @(posedge clk);
            // The arithmetic shift floors a negative level, so a half-step swing rounds up
            mag = 7 - v % 8 + v / 8;
            mag = (128 + (1 << mag) - 1) >> mag;
            pe  = 8'(128 - mag) & 8'hfe;
            check("drive pos", 32'(speaker_drive_positive), 32'(pe));
            check("drive neg", 32'(speaker_drive_negative), {24'h0, ~pe[7:1], 1'b0});
        end
        bus(1'b1, 8'h04, 32'h0);
        repeat (4) @(posedge clk);
        quiet <= 1'b1;
        rd(8'h10, 32'h25a, 32'h3ff);
        rd(8'h08, 32'h4f, 32'hff);
        rd(8'h08, 32'h0, 32'hff);
        arm();
        quiet <= 1'b0;
        bus(1'b1, 8'h04, 32'hf);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst   <= 1'b0;
        quiet <= 1'b1;
        check("reset drive", 32'(speaker_drive_positive), 32'h80);
        rd(8'h00, 32'h7, 32'hf);
        repeat (700) @(posedge clk);
        report_and_stop();
    end
endmodule : fcvp_top_bench
`default_nettype wire
